// file: hw/qdlrc_top.sv
// Purpose: pin-level control of a quad dac: serial slave, load strobe, reset
// Assumes: mclk 200 MHz; scl is the link clock; pins are asynchronous
// Notes:   command nibble, channel mask, 10-bit code left aligned in 16 bits
`timescale 1ns/100ps
module qdlrc_top
    import qdlrc_pkg::*;
#(
    parameter logic [4:0] ADDR_HI = ADDR_HI_RST
) (
    input  wire logic   mclk,
    input  wire logic   rst_n,
    input  wire logic   scl_clk,
    input  wire logic   sda_i,
    output logic        sda_o,
    output logic        sda_oe,
    input  wire logic   load_strobe_n,
    input  wire logic   dac_reset_n,
    input  wire logic   reset_level_select,
    input  wire logic   span_select,
    input  wire logic   addr_select_bit0,
    input  wire logic   addr_select_bit1,
    output qdlrc_codes_t dac_code,
    output logic        span_x2,
    output logic        ref_internal,
    output logic        ref_pin_out_en
);
    qdlrc_pins_t  pin_raw;
    qdlrc_pins_t  pin_s;
    logic [7:0]   link_byte;
    logic         link_tgl;
    logic         tgl_d_r;
    logic         scl_d_r;
    logic         sda_d_r;
    logic         strobe_d_r;
    logic         frame_rst_n_r;
    qdlrc_frame_t st_r;
    logic [1:0]   bidx_r;
    logic [23:0]  word_r;
    logic         word_done_r;
    logic         ack_pend_r;
    logic         sda_oe_r;
    logic         reset_hold_r;
    logic         rst_all_n;
    qdlrc_codes_t in_r;
    qdlrc_codes_t dac_r;
    logic [3:0]   pend_r;
    logic         span_r;
    logic         ref_int_r;
    logic         byte_ev;
    logic         start_ev;
    logic         stop_ev;
    logic         scl_fall;
    logic         strobe_fall;
    logic [9:0]   rst_code;
    logic [6:0]   own_addr;
    logic [3:0]   cmd;
    logic [3:0]   mask;
    logic [9:0]   code;

    // merge selected channels of a new code into a code set
    function automatic qdlrc_codes_t merge(input qdlrc_codes_t old,
                                           input qdlrc_codes_t nv,
                                           input logic [3:0]   sel);
        qdlrc_codes_t res;
        res = old;
        for (int i = 0; i < NCH; i++)
            if (sel[i])
                res[i] = nv[i];
        return res;
    endfunction : merge

    // every pin and the link toggle pass two flops before mclk logic uses them, except the direct dac_reset_n reset path
    assign pin_raw = '{scl: scl_clk, sda: sda_i, tgl: link_tgl,
                       strobe: load_strobe_n, span: span_select,
                       rst_pin: dac_reset_n, lvl: reset_level_select,
                       a1: addr_select_bit1, a0: addr_select_bit0};

    qdlrc_sync #(.W(PIN_W)) u_sync (
        .mclk  (mclk),
        .rst_n (rst_n),
        .d     (pin_raw),
        .q     (pin_s)
    );

    qdlrc_link u_link (
        .scl_clk     (scl_clk),
        .rst_n       (rst_n),
        .frame_rst_n (frame_rst_n_r),
        .sda_i       (sda_i),
        .byte_r      (link_byte),
        .byte_tgl_r  (link_tgl)
    );

    // edge history resets to the synchroniser's cleared level, so no false edge
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tgl_d_r    <= 1'b0;
            scl_d_r    <= 1'b0;
            sda_d_r    <= 1'b0;
            strobe_d_r <= 1'b0;
        end else begin
            tgl_d_r    <= pin_s.tgl;
            scl_d_r    <= pin_s.scl;
            sda_d_r    <= pin_s.sda;
            strobe_d_r <= pin_s.strobe;
        end
    end

    assign byte_ev     = pin_s.tgl ^ tgl_d_r;
    assign start_ev    = pin_s.scl && scl_d_r && sda_d_r && !pin_s.sda;
    assign stop_ev     = pin_s.scl && scl_d_r && !sda_d_r && pin_s.sda;
    assign scl_fall    = scl_d_r && !pin_s.scl;
    assign strobe_fall = strobe_d_r && !pin_s.strobe;
    assign own_addr    = {ADDR_HI, pin_s.a1, pin_s.a0};
    assign rst_code    = pin_s.lvl ? MID_CODE : ZERO_CODE;
    assign cmd         = word_r[CMD_POS +: 4];
    assign mask        = word_r[MASK_POS +: 4];
    assign code        = word_r[DATA_POS +: CODE_W];

    // frame tracking; link shifter is held clear outside frames
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_r          <= QDLRC_IDLE;
            frame_rst_n_r <= 1'b0;
            bidx_r        <= 2'h0;
            word_r        <= '0;
            word_done_r   <= 1'b0;
            ack_pend_r    <= 1'b0;
        end else begin
            word_done_r   <= 1'b0;
            frame_rst_n_r <= !(start_ev || stop_ev || st_r == QDLRC_IDLE);
            if (scl_fall && ack_pend_r)
                ack_pend_r <= 1'b0;
            if (start_ev) begin
                st_r       <= QDLRC_ADDR;
                frame_rst_n_r <= 1'b0;
                ack_pend_r <= 1'b0;
            end else if (stop_ev) begin
                st_r <= QDLRC_IDLE;
            end else if (byte_ev) begin
                unique case (st_r)
                    QDLRC_ADDR: begin
                        // write only; reads and other addresses go unanswered
                        if (link_byte == {own_addr, 1'b0}) begin
                            st_r       <= QDLRC_DATA;
                            bidx_r     <= 2'h0;
                            ack_pend_r <= 1'b1;
                        end else begin
                            st_r <= QDLRC_SKIP;
                        end
                    end
                    QDLRC_DATA: begin
                        word_r     <= {word_r[15:0], link_byte};
                        ack_pend_r <= 1'b1;
                        bidx_r     <= (bidx_r == BYTE_LAST) ? 2'h0 : bidx_r + 2'h1;
                        word_done_r <= (bidx_r == BYTE_LAST);
                    end
                    QDLRC_IDLE,
                    QDLRC_SKIP: begin
                    end
                endcase
            end
        end
    end

    // acknowledge: pull low from the falling edge after the byte to the next
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            sda_oe_r <= 1'b0;
        else if (start_ev || stop_ev)
            sda_oe_r <= 1'b0;
        else if (scl_fall)
            sda_oe_r <= ack_pend_r;
    end

    // reset pin clears at once; the load follows on the next clocks
    assign rst_all_n = rst_n && dac_reset_n;

    always_ff @(posedge mclk or negedge rst_all_n) begin
        if (!rst_all_n)
            reset_hold_r <= 1'b1;
        else
            reset_hold_r <= !pin_s.rst_pin;
    end

    // input and dac registers, pending mask, load strobe handling
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            in_r   <= '0;
            dac_r  <= '0;
            pend_r <= 4'h0;
        end else if (reset_hold_r) begin
            in_r   <= {NCH{rst_code}};
            dac_r  <= {NCH{rst_code}};
            pend_r <= 4'h0;
        end else if (word_done_r && (cmd == CMD_WRITE || cmd == CMD_WR_UPD)) begin
            in_r <= merge(in_r, {NCH{code}}, mask);
            // strobe held low or write-and-update: outputs follow at once
            if (cmd == CMD_WR_UPD || !pin_s.strobe) begin
                // pending channels move first, the new code lands on top
                dac_r  <= merge(merge(dac_r, in_r, pend_r), {NCH{code}}, mask);
                pend_r <= 4'h0;
            end else begin
                pend_r <= pend_r | mask;
            end
        end else if ((word_done_r && cmd == CMD_UPDATE) || strobe_fall) begin
            dac_r  <= merge(dac_r, in_r, pend_r);
            pend_r <= 4'h0;
        end
    end

    // span and reference selection
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            span_r    <= 1'b0;
            ref_int_r <= 1'b1;
        end else begin
            span_r <= pin_s.span;
            if (word_done_r && cmd == CMD_REF)
                ref_int_r <= !word_r[0];
        end
    end

    assign sda_o          = 1'b0;
    assign sda_oe         = sda_oe_r;
    assign dac_code       = dac_r;
    assign span_x2        = span_r;
    assign ref_internal   = ref_int_r;
    assign ref_pin_out_en = ref_int_r;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence s_addr_byte;
        byte_ev && !start_ev && !stop_ev && st_r == QDLRC_ADDR;
    endsequence
    sequence s_strobe_load;
        strobe_fall && !reset_hold_r && !word_done_r;
    endsequence

    property p_addr_nomatch;
        s_addr_byte ##0 (link_byte[7:1] != own_addr) |=> st_r == QDLRC_SKIP;
    endproperty
    a_addr_nomatch: assert property (p_addr_nomatch) else $error("ack on wrong address");
    property p_addr_pins;
        s_addr_byte ##0 (link_byte == {ADDR_HI, pin_s.a1, pin_s.a0, 1'b0})
            |=> st_r == QDLRC_DATA ##0 ack_pend_r;
    endproperty
    a_addr_pins: assert property (p_addr_pins) else $error("address pins not honoured");
    property p_ack_edge;
        $rose(sda_oe_r) |-> $past(scl_fall) && sda_o == 1'b0;
    endproperty
    a_ack_edge: assert property (p_ack_edge) else $error("ack not on falling edge");
    property p_word;
        byte_ev && !start_ev && !stop_ev && st_r == QDLRC_DATA && bidx_r == BYTE_LAST
            |=> word_done_r ##1 !word_done_r;
    endproperty
    a_word: assert property (p_word) else $error("word not closed after third byte");
    property p_strobe;
        s_strobe_load |=> dac_r == merge($past(dac_r), $past(in_r), $past(pend_r))
            ##0 pend_r == 4'h0;
    endproperty
    a_strobe: assert property (p_strobe) else $error("strobe did not load");
    property p_tied_low;
        word_done_r && cmd == CMD_WRITE && !pin_s.strobe && !reset_hold_r
            |=> dac_r == in_r;
    endproperty
    a_tied_low: assert property (p_tied_low) else $error("held strobe ignored");
    property p_reset_load;
        reset_hold_r ##1 reset_hold_r |-> dac_r == {NCH{$past(rst_code)}}
            && in_r == dac_r && pend_r == 4'h0;
    endproperty
    a_reset_load: assert property (p_reset_load) else $error("reset code wrong");
    property p_reset_ignore;
        reset_hold_r [*2] ##0 strobe_fall |=> $stable(dac_r);
    endproperty
    a_reset_ignore: assert property (p_reset_ignore) else $error("strobe in reset");
    property p_span;
        span_r == $past(pin_s.span);
    endproperty
    a_span: assert property (p_span) else $error("span not following pin");
    property p_soft_load;
        word_done_r && cmd == CMD_UPDATE && !reset_hold_r |=> pend_r == 4'h0;
    endproperty
    a_soft_load: assert property (p_soft_load) else $error("software load failed");
    property p_ref;
        !$past(word_done_r) |-> $stable(ref_int_r) && ref_pin_out_en == ref_int_r;
    endproperty
    a_ref: assert property (p_ref) else $error("reference changed unasked");
endmodule : qdlrc_top

// file: hw/qdlrc_pkg.sv
// Purpose: shared constants and types for the quad dac load/reset control
// Assumes: 10-bit codes, four channels, 24-bit serial word
// Notes:   command nibble layout is local to this block
package qdlrc_pkg;
    localparam int          NCH        = 4;
    localparam int          CODE_W     = 10;
    localparam int          WORD_W     = 24;
    localparam logic [3:0]  BIT_LAST   = 4'h7;   // last data bit of a byte
    localparam logic [3:0]  BIT_ACK    = 4'h8;   // ninth clock, acknowledge slot
    localparam logic [1:0]  BYTE_LAST  = 2'h2;   // third byte closes the word
    localparam logic [4:0]  ADDR_HI_RST = 5'h0c; // upper address bits, plain default
    // command nibble, word[23:20]
    localparam logic [3:0]  CMD_WRITE  = 4'h1;
    localparam logic [3:0]  CMD_UPDATE = 4'h2;
    localparam logic [3:0]  CMD_WR_UPD = 4'h3;
    localparam logic [3:0]  CMD_REF    = 4'h7;
    localparam int          CMD_POS    = 20;
    localparam int          MASK_POS   = 16;
    localparam int          DATA_POS   = 6;
    // reset codes
    localparam logic [9:0]  ZERO_CODE  = 10'h000;
    localparam logic [9:0]  MID_CODE   = 10'h200;
    // sync bundle width
    localparam int          PIN_W      = 9;

    typedef logic [NCH-1:0][CODE_W-1:0] qdlrc_codes_t;

    typedef struct packed {
        logic scl;
        logic sda;
        logic tgl;
        logic strobe;
        logic span;
        logic rst_pin;
        logic lvl;
        logic a1;
        logic a0;
    } qdlrc_pins_t;

    typedef enum logic [1:0] {
        QDLRC_IDLE,
        QDLRC_ADDR,
        QDLRC_DATA,
        QDLRC_SKIP
    } qdlrc_frame_t;
endpackage : qdlrc_pkg

// file: hw/qdlrc_sync.sv
// Purpose: two-flop synchroniser for a bundle of slow levels
// Assumes: each bit is a level held far longer than two mclk periods
// Notes:   the first stage feeds only the second
`timescale 1ns/100ps
module qdlrc_sync
    import qdlrc_pkg::*;
#(
    parameter int W = PIN_W
) (
    input  wire logic         mclk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;

    // two stages, no logic between them
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule : qdlrc_sync

// file: hw/qdlrc_link.sv
// Purpose: serial-clock side shifter, one byte per nine clocks
// Assumes: frame_rst_n is low between frames and at every start
// Notes:   byte and toggle survive frame reset so mclk sees no false edge
`timescale 1ns/100ps
module qdlrc_link
    import qdlrc_pkg::*;
(
    input  wire logic       scl_clk,
    input  wire logic       rst_n,
    input  wire logic       frame_rst_n,
    input  wire logic       sda_i,
    output logic      [7:0] byte_r,
    output logic            byte_tgl_r
);
    logic [3:0] bit_r;
    logic [6:0] shift_r;

    // bit counter and shifter, cleared by each start
    always_ff @(posedge scl_clk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            bit_r   <= 4'h0;
            shift_r <= 7'h00;
        end else begin
            bit_r   <= (bit_r == BIT_ACK) ? 4'h0 : bit_r + 4'h1;
            if (bit_r < BIT_LAST)
                shift_r <= {shift_r[5:0], sda_i};
        end
    end

    // finished byte is held for a full byte time, so mclk reads it safely
    always_ff @(posedge scl_clk or negedge rst_n) begin
        if (!rst_n) begin
            byte_r     <= 8'h00;
            byte_tgl_r <= 1'b0;
        end else if (bit_r == BIT_LAST && frame_rst_n) begin
            byte_r     <= {shift_r, sda_i};
            byte_tgl_r <= ~byte_tgl_r;
        end
    end
endmodule : qdlrc_link

// file: bench/qdlrc_i2c_master.sv
// Purpose: behavioural two-wire bus master for the quad dac control bench
// Assumes: the bench resolves the open-drain line with a pull-up
// Notes:   scl stands high between frames; data moves a quarter of the half period after scl falls
`timescale 1ns/100ps
module qdlrc_i2c_master #(
    parameter int HALF = 103
) (
    output logic      scl,
    output logic      sda_oe,
    input  wire logic sda
);
    localparam int Q = HALF / 4;
    // idle bus: clock high, line released
    initial begin
        scl    = 1'b1;
        sda_oe = 1'b0;
    end
    // the quarter delay keeps data edges clear of start and stop look-alikes
    task automatic put_bit(input logic b);
        #Q sda_oe = ~b;
        #(HALF - Q) scl = 1'b1;
        #HALF scl = 1'b0;
    endtask : put_bit
    // msb first, then release for the ninth clock and read the answer
    task automatic wr_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            put_bit(b[i]);
        end
        #Q sda_oe = 1'b0;
        #(HALF - Q) scl = 1'b1;
        #(HALF / 2) ack = ~sda;
        #(HALF - HALF / 2) scl = 1'b0;
    endtask : wr_byte
    // start, write address, three bytes of one word, stop
    task automatic frame(input logic [6:0] adr, input logic [7:0] b1, input logic [7:0] b2,
                         input logic [7:0] b3, output logic [3:0] acks);
        sda_oe = 1'b1;
        #HALF scl = 1'b0;
        wr_byte({adr, 1'b0}, acks[3]);
        wr_byte(b1, acks[2]);
        wr_byte(b2, acks[1]);
        wr_byte(b3, acks[0]);
        #Q sda_oe = 1'b1;
        #(HALF - Q) scl = 1'b1;
        #HALF sda_oe = 1'b0;
        #(2 * HALF);
    endtask : frame
endmodule : qdlrc_i2c_master

// file: bench/tb_qdlrc_top.sv
// Purpose: self-checking bench for the quad dac load and reset control
// Assumes: expected codes are tracked by a small model of input and dac registers
// Notes:   write-and-load rows leave no other channel pending, so masking stays moot
`timescale 1ns/100ps
module tb_qdlrc_top
    import qdlrc_pkg::*;
;
    typedef struct packed {
        logic       a1;
        logic       a0;
        logic       ok;
        logic [3:0] cmd;
        logic [3:0] mask;
        logic [9:0] code;
        logic       pulse;
        logic       ext;
    } qdlrc_row_t;
    qdlrc_row_t rows [8] = '{
        '{1'b0, 1'b0, 1'b1, CMD_WRITE, 4'h1, 10'h155, 1'b0, 1'b0},
        '{1'b0, 1'b1, 1'b1, CMD_WRITE, 4'h2, 10'h2aa, 1'b1, 1'b0},
        '{1'b1, 1'b0, 1'b1, CMD_WRITE, 4'ha, 10'h3ff, 1'b0, 1'b0},
        '{1'b1, 1'b0, 1'b1, CMD_UPDATE, 4'h0, 10'h000, 1'b0, 1'b0},
        '{1'b1, 1'b1, 1'b1, CMD_WR_UPD, 4'h4, 10'h0a5, 1'b0, 1'b0},
        '{1'b1, 1'b1, 1'b0, CMD_WR_UPD, 4'hf, 10'h001, 1'b0, 1'b0},
        '{1'b0, 1'b1, 1'b1, CMD_REF, 4'h0, 10'h000, 1'b0, 1'b1},
        '{1'b0, 1'b0, 1'b1, CMD_REF, 4'h0, 10'h000, 1'b0, 1'b0}};
    logic         mclk, rst_n, scl_clk, m_oe, sda_o, sda_oe, load_strobe_n, dac_reset_n;
    logic         reset_level_select, span_select, addr_select_bit0, addr_select_bit1;
    logic         span_x2, ref_internal, ref_pin_out_en, eref;
    logic   [3:0] pend, acks;
    wire logic    sda_line;
    qdlrc_codes_t dac_code, exp_in, exp_dac;
    qdlrc_row_t   r;
    int           err_total, samples_checked, cyc;
    // released line floats high through the pull-up
    assign sda_line = (m_oe | sda_oe) ? 1'b0 : 1'b1;
    qdlrc_top dut (.mclk(mclk), .rst_n(rst_n), .scl_clk(scl_clk), .sda_i(sda_line),
        .sda_o(sda_o), .sda_oe(sda_oe), .load_strobe_n(load_strobe_n),
        .dac_reset_n(dac_reset_n), .reset_level_select(reset_level_select),
        .span_select(span_select), .addr_select_bit0(addr_select_bit0),
        .addr_select_bit1(addr_select_bit1), .dac_code(dac_code), .span_x2(span_x2),
        .ref_internal(ref_internal), .ref_pin_out_en(ref_pin_out_en));
    qdlrc_i2c_master u_mst (.scl(scl_clk), .sda_oe(m_oe), .sda(sda_line));
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : summarize
    // a hung handshake ends the run here
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            err_total++;
            summarize();
        end
    end
    task automatic chk_val(input string nm, input logic [9:0] exp, input logic [9:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s exp %h got %h", nm, exp, got);
        end
    endtask : chk_val
    task automatic chk_codes(input string nm, input qdlrc_codes_t exp, input qdlrc_codes_t got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s exp %h got %h", nm, exp, got);
        end
    endtask : chk_codes
    // pending input registers move to the dac registers together
    task automatic load_pend();
        for (int i = 0; i < NCH; i++) begin
            if (pend[i])
                exp_dac[i] = exp_in[i];
        end
        pend = 4'h0;
    endtask : load_pend
    task automatic model(input logic [3:0] cmd, input logic [3:0] mask,
                         input logic [9:0] code, input logic ext, input logic now);
        for (int i = 0; i < NCH; i++) begin
            if (mask[i] && (cmd == CMD_WRITE || cmd == CMD_WR_UPD)) begin
                exp_in[i] = code;
                pend[i]   = 1'b1;
            end
        end
        if (cmd == CMD_REF)
            eref = ~ext;
        if (now || cmd == CMD_UPDATE || cmd == CMD_WR_UPD)
            load_pend();
    endtask : model
    task automatic pulse();
        @(negedge mclk) load_strobe_n <= 1'b0;
        repeat (6) @(negedge mclk);
        load_strobe_n <= 1'b1;
        repeat (8) @(negedge mclk);
    endtask : pulse
    task automatic run_word(input logic [6:0] adr, input logic [3:0] cmd, input logic [3:0] mask,
                            input logic [9:0] code, input logic ext);
        logic [15:0] w;
        w = {code, 5'h00, ext};
        u_mst.frame(adr, {cmd, mask}, w[15:8], w[7:0], acks);
        repeat (8) @(negedge mclk);
    endtask : run_word
    initial begin
        {rst_n, span_select, addr_select_bit0, addr_select_bit1} = '0;
        {load_strobe_n, dac_reset_n, reset_level_select, eref} = 4'hf;
        {err_total, samples_checked, pend} = '0;
        exp_in  = {NCH{MID_CODE}};
        exp_dac = {NCH{MID_CODE}};
        repeat (10) @(negedge mclk);
        rst_n <= 1'b1;
        repeat (12) @(negedge mclk);
        chk_codes("dac_code", exp_dac, dac_code);
        chk_val("ref_pin_out_en", {9'h0, eref}, {9'h0, ref_pin_out_en});
        // ordinary words: every address pin pair, every command
        for (int i = 0; i < 8; i++) begin
            r = rows[i];
            @(negedge mclk) {addr_select_bit1, addr_select_bit0} <= {r.a1, r.a0};
            repeat (6) @(negedge mclk);
            run_word({ADDR_HI_RST, r.a1, r.a0 ^ ~r.ok}, r.cmd, r.mask, r.code, r.ext);
            chk_val("acks", {6'h0, {4{r.ok}}}, {6'h0, acks});
            if (r.ok)
                model(r.cmd, r.mask, r.code, r.ext, 1'b0);
            if (r.pulse) begin
                pulse();
                load_pend();
            end
            chk_codes("dac_code", exp_dac, dac_code);
            chk_val("ref_internal", {9'h0, eref}, {9'h0, ref_internal});
            chk_val("sda_o", 10'h000, {9'h0, sda_o});
            $display("test %0d done", i);
        end
        // strobe tied low: each write lands at once
        @(negedge mclk) load_strobe_n <= 1'b0;
        repeat (6) @(negedge mclk);
        run_word({ADDR_HI_RST, 2'h0}, CMD_WRITE, 4'h8, 10'h123, 1'b0);
        model(CMD_WRITE, 4'h8, 10'h123, 1'b0, 1'b1);
        chk_codes("dac_code", exp_dac, dac_code);
        load_strobe_n <= 1'b1;
        $display("test tied done");
        // pending write, then reset pin to zero scale, strobe ignored meanwhile
        run_word({ADDR_HI_RST, 2'h0}, CMD_WRITE, 4'h1, 10'h0ff, 1'b0);
        @(negedge mclk) {reset_level_select, dac_reset_n} <= 2'h0;
        {exp_in, exp_dac, pend} = '0;
        repeat (4) @(negedge mclk);
        chk_codes("dac_code", exp_dac, dac_code);
        pulse();
        chk_codes("dac_code", exp_dac, dac_code);
        dac_reset_n <= 1'b1;
        repeat (8) @(negedge mclk);
        run_word({ADDR_HI_RST, 2'h0}, CMD_UPDATE, 4'hf, 10'h000, 1'b0);
        chk_codes("dac_code", exp_dac, dac_code);
        $display("test reset done");
        // span pin both ways
        span_select <= 1'b1;
        repeat (6) @(negedge mclk);
        chk_val("span_x2", 10'h001, {9'h0, span_x2});
        span_select <= 1'b0;
        repeat (6) @(negedge mclk);
        chk_val("span_x2", 10'h000, {9'h0, span_x2});
        $display("test span done");
        summarize();
    end
endmodule : tb_qdlrc_top
